// File: common/epsc_pkg.sv
// epsc_pkg: constants shared by the position / edge-separation counter
// assumes: AXI4-Lite slave with 32-bit data, one clock CLK at 100 MHz
package epsc_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] EPSC_CTRL_OFF = 8'h00;
	localparam logic [7:0] EPSC_RELOAD_OFF = 8'h04;
	localparam logic [7:0] EPSC_COUNT_OFF = 8'h08;
	localparam logic [7:0] EPSC_STATUS_OFF = 8'h0C;
	localparam logic [7:0] EPSC_RESULT_OFF = 8'h10;
	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int EPSC_ARM_BIT = 0;
	localparam int EPSC_MEAS_LSB = 1;
	localparam int EPSC_DEC_LSB = 4;
	localparam int EPSC_ZPH_LSB = 6;
	localparam int EPSC_ZEN_BIT = 8;
	localparam int EPSC_GPOL_BIT = 9;
	localparam int EPSC_APOL_BIT = 10;
	localparam int EPSC_SPOL_BIT = 11;
	localparam int EPSC_OVCLR_BIT = 12;
	localparam logic [31:0] EPSC_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] EPSC_RELOAD_RST = 32'h0000_0000;
	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		EPSC_M_POS_SINGLE = 3'h0,
		EPSC_M_POS_SAMPLED = 3'h1,
		EPSC_M_SEP_SINGLE = 3'h2,
		EPSC_M_SEP_IMPLICIT = 3'h3,
		EPSC_M_SEP_SAMPLED = 3'h4,
		EPSC_M_SEP_HARDWARE_TIMED_SINGLE_POINT = 3'h5
	} epsc_mode_t;
	typedef enum logic [1:0]
	{
		EPSC_D_SINGLE = 2'h0,
		EPSC_D_DOUBLE = 2'h1,
		EPSC_D_QUAD = 2'h2,
		EPSC_D_TWO_PULSE = 2'h3
	} epsc_dec_t;
	typedef enum logic [1:0]
	{
		EPSC_S_IDLE = 2'h0,
		EPSC_S_WAIT_AUX = 2'h1,
		EPSC_S_COUNT = 2'h2,
		EPSC_S_DONE = 2'h3
	} epsc_sep_t;
	localparam int EPSC_SYNC_STAGES = 2;
endpackage

// File: logic/epsc_sync.sv
// epsc_sync: two-flop synchroniser with edge outputs taken after the second stage
// assumes: input is asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module epsc_sync
	import epsc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic d,
	output logic q,
	output logic rise,
	output logic fall
);
	logic meta;
	logic stable;
	logic prev;
	// ----------------------------------------
	// two flops, then edge history
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			meta <= 1'b0;
			stable <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= d;
			stable <= meta;
			prev <= stable;
		end
	end
	assign q = stable;
	assign rise = stable & ~prev;
	assign fall = ~stable & prev;
endmodule // epsc_sync
`default_nettype wire

// File: logic/epsc_quad.sv
// epsc_quad: turns synchronised A/B levels and edges into count steps
// assumes: inputs already synchronised to CLK
`timescale 1ns/1ps
`default_nettype none
module epsc_quad
	import epsc_pkg::*;
(
	input wire logic a,
	input wire logic b,
	input wire logic a_rise,
	input wire logic a_fall,
	input wire logic b_rise,
	input wire logic b_fall,
	input wire epsc_dec_t dec,
	output logic up,
	output logic down
);
	// direction from which channel moved relative to the other's level
	wire a_edge = a_rise | a_fall;
	wire b_edge = b_rise | b_fall;
	wire a_fwd = (a_rise & ~b) | (a_fall & b); // a leads b
	wire b_fwd = (b_rise & a) | (b_fall & ~a);
	wire x1_up = a_rise & ~b;
	wire x1_dn = a_fall & ~b;
	wire x2_up = a_fwd;
	wire x2_dn = a_edge & ~a_fwd;
	wire x4_up = a_fwd | b_fwd;
	wire x4_dn = (a_edge & ~a_fwd) | (b_edge & ~b_fwd);
	// select step by decoding mode
	assign up = (dec == EPSC_D_SINGLE) ? x1_up :
		(dec == EPSC_D_DOUBLE) ? x2_up :
		(dec == EPSC_D_QUAD) ? (x4_up & ~x4_dn) :
		(a_rise & ~b_rise);
	assign down = (dec == EPSC_D_SINGLE) ? x1_dn :
		(dec == EPSC_D_DOUBLE) ? x2_dn :
		(dec == EPSC_D_QUAD) ? (x4_dn & ~x4_up) :
		(b_rise & ~a_rise);
endmodule // epsc_quad
`default_nettype wire

// File: logic/epsc_top.sv
// epsc_top: encoder position and two-signal edge-separation counter
// assumes: AXI4-Lite master on CLK; pins asynchronous; DMA drains the result stream
//
// How it works
// - single-edge: up on A rise with B low, down on A fall with B low
// - double-edge: count both A edges, direction by phase lead
// - quad-edge: count every A and B edge, direction by phase lead
// - index high in selected phase loads the reload value (not in two-pulse decoding)
// - reload phase selectable among the four A/B level pairs
// - a coincident step is applied first, then the reload
// - reload completes within one clock of the phase becoming true
// - after reload counting carries on from the reloaded value
// - two-pulse: up on an A rise, down on a B rise; coincident A and B rises cancel
// - sampled position captures count on selectable gate edge
// - sample edges never clear the count; values cumulative since arm
// - captured samples leave as a valid/ready stream to DMA
// - armed, an aux edge starts source counting; later aux edges ignored
// - a gate edge stops counting and stores the count
// - aux and gate active edges each selectable rising or falling
// - counted source edge selectable rising or falling
// - single separation stores one count then ignores all inputs
// - implicit: next gate edge after a result returns to waiting for an aux edge
// - sampled and single-point separation store on a sample clock edge
// - single-point flags overrun if aux and gate not both seen
`timescale 1ns/1ps
`default_nettype none
module epsc_top
	import epsc_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic ENC_A,
	input wire logic ENC_B,
	input wire logic ENC_INDEX,
	input wire logic GATE,
	input wire logic AUX,
	input wire logic SOURCE,
	output logic [CNT_W-1:0] SAMPLE_DATA,
	output logic SAMPLE_VALID,
	input wire logic SAMPLE_READY
);
	if (CNT_W < 1 || CNT_W > 32)
	begin : g_bad_width
		$error("CNT_W must be 1..32");
	end
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [5:0] pin_raw;
	logic [5:0] pin_q;
	logic [5:0] pin_rise;
	logic [5:0] pin_fall;
	assign pin_raw = {SOURCE, AUX, GATE, ENC_INDEX, ENC_B, ENC_A};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_sync
			epsc_sync u_sync
			(
				.CLK(CLK),
				.RESETN(RESETN),
				.d(pin_raw[gi]),
				.q(pin_q[gi]),
				.rise(pin_rise[gi]),
				.fall(pin_fall[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [31:0] reload;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] result;
	logic result_full;
	logic overrun;
	epsc_sep_t sep_state;
	wire armed = ctrl[EPSC_ARM_BIT];
	wire epsc_mode_t mode = epsc_mode_t'(ctrl[EPSC_MEAS_LSB +: 3]);
	wire epsc_dec_t dec = epsc_dec_t'(ctrl[EPSC_DEC_LSB +: 2]);
	wire [1:0] z_phase = ctrl[EPSC_ZPH_LSB +: 2];
	wire z_en = ctrl[EPSC_ZEN_BIT];
	// edges with configurable polarity
	wire gate_act = ctrl[EPSC_GPOL_BIT] ? pin_fall[3] : pin_rise[3];
	wire aux_act = ctrl[EPSC_APOL_BIT] ? pin_fall[4] : pin_rise[4];
	wire src_act = ctrl[EPSC_SPOL_BIT] ? pin_fall[5] : pin_rise[5];
	wire pos_mode = (mode == EPSC_M_POS_SINGLE) || (mode == EPSC_M_POS_SAMPLED);
	wire sclk_mode = (mode == EPSC_M_SEP_SAMPLED) || (mode == EPSC_M_SEP_HARDWARE_TIMED_SINGLE_POINT);
	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign AWREADY = ~aw_held & ~BVALID;
	assign WREADY = ~w_held & ~BVALID;
	wire wr_go = aw_held & w_held & ~BVALID;
	wire wr_ctrl = wr_go && aw_addr == EPSC_CTRL_OFF;
	wire wr_reload = wr_go && aw_addr == EPSC_RELOAD_OFF;
	wire wr_known = wr_ctrl | wr_reload | (wr_go && aw_addr == EPSC_STATUS_OFF);
	wire ov_clear = wr_ctrl && w_strb[1] && w_data[EPSC_OVCLR_BIT];
	wire arm_rise = wr_ctrl && w_strb[0] && w_data[EPSC_ARM_BIT] && !armed;
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= 2'h0;
			ctrl <= EPSC_CTRL_RST;
			reload <= EPSC_RELOAD_RST;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_known ? 2'h0 : 2'h2;
			end
			else if (BREADY)
				BVALID <= 1'b0;
			if (wr_ctrl)
				ctrl <= merge(ctrl, w_data, w_strb) & ~(32'h1 << EPSC_OVCLR_BIT);
			if (wr_reload)
				reload <= merge(reload, w_data, w_strb);
		end
	end
	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	wire [31:0] status_word = {28'h0, overrun, result_full, sep_state};
	wire [31:0] rd_mux = (ARADDR == EPSC_CTRL_OFF) ? ctrl :
		(ARADDR == EPSC_RELOAD_OFF) ? reload :
		(ARADDR == EPSC_COUNT_OFF) ? 32'(count) :
		(ARADDR == EPSC_STATUS_OFF) ? status_word :
		(ARADDR == EPSC_RESULT_OFF) ? 32'(result) : 32'h0000_0000;
	wire rd_known = (ARADDR == EPSC_CTRL_OFF) || (ARADDR == EPSC_RELOAD_OFF) || (ARADDR == EPSC_COUNT_OFF) ||
		(ARADDR == EPSC_STATUS_OFF) || (ARADDR == EPSC_RESULT_OFF);
	wire rd_take = ARVALID && ARREADY;
	wire rd_result = rd_take && ARADDR == EPSC_RESULT_OFF;
	assign ARREADY = ~RVALID;
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= 2'h0;
		end
		else if (rd_take)
		begin
			RVALID <= 1'b1;
			RDATA <= rd_mux;
			RRESP <= rd_known ? 2'h0 : 2'h2;
		end
		else if (RREADY)
			RVALID <= 1'b0;
	end
	// ----------------------------------------
	// position step and index reload
	// ----------------------------------------
	logic step_up;
	logic step_dn;
	epsc_quad u_quad
	(
		.a(pin_q[0]),
		.b(pin_q[1]),
		.a_rise(pin_rise[0]),
		.a_fall(pin_fall[0]),
		.b_rise(pin_rise[1]),
		.b_fall(pin_fall[1]),
		.dec(dec),
		.up(step_up),
		.down(step_dn)
	);
	// level-sensitive: same cycle the phase and index are seen
	wire z_load = pos_mode && z_en && dec != EPSC_D_TWO_PULSE && pin_q[2] &&
		{pin_q[1], pin_q[0]} == z_phase;
	wire [CNT_W-1:0] stepped = step_up ? count + 1'b1 : step_dn ? count - 1'b1 : count;
	// ----------------------------------------
	// edge-separation sequencing
	// ----------------------------------------
	wire sample_edge = gate_act && (mode == EPSC_M_POS_SAMPLED || sclk_mode);
	wire push = SAMPLE_VALID && SAMPLE_READY;
	logic aux_seen;
	logic gate_seen;
	epsc_sep_t next_sep;
	always_comb
	begin
		next_sep = sep_state;
		case (sep_state)
			EPSC_S_IDLE:
				next_sep = (!pos_mode && armed) ? EPSC_S_WAIT_AUX : EPSC_S_IDLE;
			EPSC_S_WAIT_AUX:
				if (aux_act) next_sep = EPSC_S_COUNT;
			EPSC_S_COUNT:
				if (gate_act && !sclk_mode) next_sep = EPSC_S_DONE;
				else if (gate_act) next_sep = EPSC_S_WAIT_AUX;
			EPSC_S_DONE:
				if (mode == EPSC_M_SEP_IMPLICIT && gate_act) next_sep = EPSC_S_WAIT_AUX;
			default:
				next_sep = EPSC_S_IDLE;
		endcase
		if (!armed || pos_mode)
			next_sep = EPSC_S_IDLE;
	end
	// ----------------------------------------
	// counter, result and stream
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			count <= '0;
			sep_state <= EPSC_S_IDLE;
			result <= '0;
			result_full <= 1'b0;
			SAMPLE_VALID <= 1'b0;
			SAMPLE_DATA <= '0;
			overrun <= 1'b0;
			aux_seen <= 1'b0;
			gate_seen <= 1'b0;
		end
		else
		begin
			sep_state <= next_sep;
			if (push)
				SAMPLE_VALID <= 1'b0;
			// clear before the store below so a coincident store wins
			if (rd_result || arm_rise)
				result_full <= 1'b0;
			if (arm_rise)
				count <= '0;
			else if (armed && pos_mode)
				count <= z_load ? reload[CNT_W-1:0] : stepped;
			else if (armed && sep_state == EPSC_S_COUNT && !(gate_act && !sclk_mode) && src_act)
				count <= count + 1'b1;
			else if (armed && sep_state == EPSC_S_WAIT_AUX && aux_act)
				count <= '0;
			// position sample on gate edge, count untouched
			if (armed && mode == EPSC_M_POS_SAMPLED && sample_edge)
			begin
				SAMPLE_DATA <= count;
				SAMPLE_VALID <= 1'b1;
			end
			// separation interval ends
			if (sep_state == EPSC_S_COUNT && gate_act && !sclk_mode)
			begin
				result <= count;
				result_full <= 1'b1;
				if (mode == EPSC_M_SEP_IMPLICIT)
				begin
					SAMPLE_DATA <= count;
					SAMPLE_VALID <= 1'b1;
				end
			end
			// a fresh arm forgets edges seen before it
			if (arm_rise)
			begin
				aux_seen <= 1'b0;
				gate_seen <= 1'b0;
			end
			// sample-clocked separation store and overrun check; this gate edge is also the stop
			if (armed && sclk_mode && sample_edge)
			begin
				SAMPLE_DATA <= count;
				SAMPLE_VALID <= 1'b1;
				result <= count;
				if (mode == EPSC_M_SEP_HARDWARE_TIMED_SINGLE_POINT && !(aux_seen && (gate_seen || sep_state == EPSC_S_COUNT)))
					overrun <= 1'b1;
				else if (ov_clear)
					overrun <= 1'b0;
				aux_seen <= 1'b0;
				gate_seen <= 1'b0;
			end
			else
			begin
				if (aux_act) aux_seen <= 1'b1;
				if (gate_act && sep_state == EPSC_S_COUNT) gate_seen <= 1'b1;
				if (ov_clear) overrun <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence zphase_s;
		armed && z_load && !arm_rise;
	endsequence
	reload_load_a: assert property (@(posedge CLK) disable iff (!RESETN)
		zphase_s |=> count == $past(reload[CNT_W-1:0])) else $error("index reload missed");
	unarmed_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!armed && !arm_rise && !$past(arm_rise) |=> count == $past(count)) else $error("count moved unarmed");
	step_up_a: assert property (@(posedge CLK) disable iff (!RESETN)
		armed && pos_mode && step_up && !z_load && !arm_rise |=> count == $past(count) + 1'b1)
		else $error("up step lost");
	step_dn_a: assert property (@(posedge CLK) disable iff (!RESETN)
		armed && pos_mode && step_dn && !z_load && !arm_rise |=> count == $past(count) - 1'b1)
		else $error("down step lost");
	sample_keep_a: assert property (@(posedge CLK) disable iff (!RESETN)
		armed && mode == EPSC_M_POS_SAMPLED && sample_edge |=> SAMPLE_VALID && SAMPLE_DATA == $past(count))
		else $error("position sample wrong");
	aux_start_a: assert property (@(posedge CLK) disable iff (!RESETN)
		sep_state == EPSC_S_WAIT_AUX && aux_act && armed && !pos_mode |=> sep_state == EPSC_S_COUNT)
		else $error("aux did not start");
	gate_stop_a: assert property (@(posedge CLK) disable iff (!RESETN)
		sep_state == EPSC_S_COUNT && gate_act && !sclk_mode && armed && !pos_mode
		|=> sep_state == EPSC_S_DONE && result == $past(count)) else $error("gate stop wrong");
	overrun_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
		armed && mode == EPSC_M_SEP_HARDWARE_TIMED_SINGLE_POINT && sample_edge && !aux_seen |=> overrun)
		else $error("overrun not flagged");
	single_done_a: assert property (@(posedge CLK) disable iff (!RESETN)
		sep_state == EPSC_S_DONE && mode == EPSC_M_SEP_SINGLE && armed |=> sep_state == EPSC_S_DONE)
		else $error("single mode left done");
endmodule // epsc_top
`default_nettype wire

// File: bench/epsc_sig_model.sv
// epsc_sig_model: encoder and timing-signal source on the counter pins
// assumes: tasks are called just after a rising CLK edge
`timescale 1ns/1ps
`default_nettype none
module epsc_sig_model
(
	input wire logic CLK,
	output logic ENC_A,
	output logic ENC_B,
	output logic ENC_INDEX,
	output logic GATE,
	output logic AUX,
	output logic SOURCE
);
	// ----------------------------------------
	// pin levels, each held at least five clocks
	// ----------------------------------------
	logic [5:0] pins = 6'h00;
	logic [1:0] phase = 2'h0;
	assign {SOURCE, AUX, GATE, ENC_INDEX, ENC_B, ENC_A} = pins;
	// one level change, long enough for the synchroniser
	task automatic set_pin(input int i, input logic v);
		@(posedge CLK);
		pins[i] <= v;
		repeat (4) @(posedge CLK);
	endtask
	// whole pulses on one pin
	task automatic pulse(input int i, input int n);
		repeat (n)
		begin
			set_pin(i, 1'b1);
			set_pin(i, 1'b0);
		end
	endtask
	// gray-coded quadrature steps, forward has A leading B
	task automatic step(input logic fwd, input int n);
		repeat (n)
		begin
			phase = fwd ? phase + 2'h1 : phase - 2'h1;
			@(posedge CLK);
			pins[1:0] <= {phase[1], phase[1] ^ phase[0]};
			repeat (4) @(posedge CLK);
		end
	endtask
endmodule // epsc_sig_model
`default_nettype wire

// File: bench/epsc_bench.sv
// epsc_bench: self-checking bench for epsc_top
// assumes: AXI4-Lite master here, pins from epsc_sig_model
`timescale 1ns/1ps
`default_nettype none
module epsc_bench
	import epsc_pkg::*;
;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [7:0] AWADDR = 8'h00;
	logic AWVALID = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic WVALID = 1'b0;
	logic BREADY = 1'b0;
	logic [7:0] ARADDR = 8'h00;
	logic ARVALID = 1'b0;
	logic RREADY = 1'b0;
	logic SAMPLE_READY = 1'b0;
	wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_VALID;
	wire logic [1:0] BRESP, RRESP;
	wire logic [31:0] RDATA, SAMPLE_DATA;
	wire logic ENC_A, ENC_B, ENC_INDEX, GATE, AUX, SOURCE;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] d;
	logic [1:0] r;
	// ----------------------------------------
	// clock, timeout, instances
	// ----------------------------------------
	always #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			close_out();
		end
	end
	epsc_top u_epsc_top (.CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_INDEX(ENC_INDEX), .GATE(GATE),
		.AUX(AUX), .SOURCE(SOURCE), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE_READY(SAMPLE_READY));
	epsc_sig_model u_epsc_sig_model (.CLK(CLK), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_INDEX(ENC_INDEX),
		.GATE(GATE), .AUX(AUX), .SOURCE(SOURCE));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// write: offer AW and W together, hold bready until the response
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_ok, w_ok, b_ok;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok)
		begin
			@(negedge CLK);
			aw_ok = AWVALID & AWREADY;
			w_ok = WVALID & WREADY;
			b_ok = BVALID;
			resp = BRESP;
			@(posedge CLK);
			if (aw_ok)
				AWVALID <= 1'b0;
			if (w_ok)
				WVALID <= 1'b0;
		end
		BREADY <= 1'b0;
	endtask
	// read: hold rready until rvalid is seen
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ar_ok, r_ok;
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok)
		begin
			@(negedge CLK);
			ar_ok = ARVALID & ARREADY;
			r_ok = RVALID;
			v = RDATA;
			resp = RRESP;
			@(posedge CLK);
			if (ar_ok)
				ARVALID <= 1'b0;
		end
		RREADY <= 1'b0;
	endtask
	task automatic get_sample(output logic [31:0] v);
		logic ok;
		@(posedge CLK);
		SAMPLE_READY <= 1'b1;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge CLK);
			ok = SAMPLE_VALID;
			v = SAMPLE_DATA;
			@(posedge CLK);
		end
		SAMPLE_READY <= 1'b0;
	endtask
	function automatic logic [31:0] cfg(input logic [2:0] m, input logic [1:0] dc, input logic [1:0] zp,
		input logic ze, input logic g, input logic au, input logic s);
		return {20'h0, s, au, g, ze, zp, dc, m, 1'b0};
	endfunction
	// disarm then arm, draining any stale sample meanwhile
	task automatic arm(input logic [31:0] c);
		@(posedge CLK);
		SAMPLE_READY <= 1'b1;
		axi_write(EPSC_CTRL_OFF, c, r);
		axi_write(EPSC_CTRL_OFF, c | 32'h1, r);
		SAMPLE_READY <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		axi_read(EPSC_CTRL_OFF, d, r);
		check("ctrl reset", EPSC_CTRL_RST, d);
		axi_read(EPSC_RELOAD_OFF, d, r);
		check("reload reset", EPSC_RELOAD_RST, d);
		axi_read(8'h14, d, r);
		check("unmapped rresp", 32'h2, {30'h0, r});
		check("unmapped rdata", 32'h0, d);
		axi_write(8'h14, 32'hA5, r);
		check("unmapped bresp", 32'h2, {30'h0, r});
		$display("regs done");
	endtask
	task automatic t_decode();
		axi_write(EPSC_CTRL_OFF, cfg(3'h0, EPSC_D_QUAD, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), r);
		u_epsc_sig_model.step(1'b1, 4);
		axi_read(EPSC_COUNT_OFF, d, r);
		check("unarmed count", 32'h0, d);
		for (int k = 0; k < 3; k++)
		begin
			arm(cfg(3'h0, k[1:0], 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
			u_epsc_sig_model.step(1'b1, 16);
			u_epsc_sig_model.step(1'b0, 8);
			axi_read(EPSC_COUNT_OFF, d, r);
			check("decoded count", 32'h2 << k, d);
		end
		arm(cfg(3'h0, EPSC_D_TWO_PULSE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		u_epsc_sig_model.pulse(0, 3);
		u_epsc_sig_model.pulse(1, 1);
		axi_read(EPSC_COUNT_OFF, d, r);
		check("two-pulse count", 32'h2, d);
		$display("decode done");
	endtask
	task automatic t_index();
		logic [1:0] q;
		axi_write(EPSC_RELOAD_OFF, 32'h64, r);
		for (int p = 0; p < 4; p++)
		begin
			q = p[1:0];
			arm(cfg(3'h0, EPSC_D_QUAD, {q[1], q[1] ^ q[0]}, 1'b1, 1'b0, 1'b0, 1'b0));
			u_epsc_sig_model.set_pin(2, 1'b1);
			u_epsc_sig_model.step(1'b1, 4);
			axi_read(EPSC_COUNT_OFF, d, r);
			check("reload count", 32'h64 + ((32'h4 - p) & 32'h3), d);
			u_epsc_sig_model.set_pin(2, 1'b0);
			u_epsc_sig_model.step(1'b1, 4);
			axi_read(EPSC_COUNT_OFF, d, r);
			check("count after reload", 32'h68 + ((32'h4 - p) & 32'h3), d);
		end
		$display("index done");
	endtask
	task automatic t_sampled();
		arm(cfg(3'h1, EPSC_D_QUAD, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		u_epsc_sig_model.step(1'b1, 8);
		u_epsc_sig_model.set_pin(3, 1'b1);
		get_sample(d);
		check("rising sample", 32'h8, d);
		u_epsc_sig_model.step(1'b1, 4);
		axi_write(EPSC_CTRL_OFF, cfg(3'h1, EPSC_D_QUAD, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0) | 32'h1, r);
		u_epsc_sig_model.set_pin(3, 1'b0);
		get_sample(d);
		check("falling sample", 32'hC, d);
		$display("sampled done");
	endtask
	task automatic t_sep();
		arm(cfg(3'h2, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		u_epsc_sig_model.set_pin(4, 1'b1);
		u_epsc_sig_model.pulse(5, 2);
		u_epsc_sig_model.set_pin(4, 1'b0);
		u_epsc_sig_model.pulse(5, 5);
		u_epsc_sig_model.pulse(4, 1);
		u_epsc_sig_model.pulse(5, 2);
		u_epsc_sig_model.pulse(3, 1);
		u_epsc_sig_model.pulse(5, 3);
		u_epsc_sig_model.pulse(4, 1);
		u_epsc_sig_model.pulse(3, 1);
		axi_read(EPSC_RESULT_OFF, d, r);
		check("single result", 32'h7, d);
		arm(cfg(3'h3, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
		u_epsc_sig_model.set_pin(5, 1'b1);
		u_epsc_sig_model.pulse(4, 1);
		u_epsc_sig_model.set_pin(5, 1'b0);
		u_epsc_sig_model.pulse(5, 3);
		u_epsc_sig_model.set_pin(3, 1'b1);
		get_sample(d);
		check("implicit result", 32'h4, d);
		u_epsc_sig_model.set_pin(3, 1'b0);
		for (int m = 4; m < 6; m++)
		begin
			arm(cfg(m[2:0], 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
			u_epsc_sig_model.pulse(4, 1);
			u_epsc_sig_model.pulse(5, 2);
			u_epsc_sig_model.pulse(3, 1);
			get_sample(d);
			check("clocked result", 32'h2, d);
		end
		u_epsc_sig_model.pulse(3, 1);
		axi_read(EPSC_STATUS_OFF, d, r);
		check("overrun set", 32'h1, {31'h0, d[3]});
		axi_write(EPSC_CTRL_OFF, cfg(3'h5, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0) | 32'h1001, r);
		axi_read(EPSC_STATUS_OFF, d, r);
		check("overrun cleared", 32'h0, {31'h0, d[3]});
		$display("separation done");
	endtask
	// ----------------------------------------
	// verdict and main sequence
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge CLK);
		RESETN <= 1'b1;
		t_regs();
		t_decode();
		t_index();
		t_sampled();
		t_sep();
		close_out();
	end
endmodule // epsc_bench
`default_nettype wire
